// [include/tsr_cfg.svh]
// Summary of operation
// - Five registers exist; one selector picks which data register every access uses.
// - Selector keeps pointing at the same register over any number of reads.
// - First write byte after the address is always taken as the selector byte.
// - Only selector values 00h to 03h load; others are ignored but acknowledged.
// - Address 1001 plus strap bits is acknowledged, then the selector byte is acknowledged.
// - Selector resets to the temperature register location.
// - Temperature register is 16-bit read-only two's complement, up to 12 bits.
// - Bit 15 of the temperature word is the sign.
// - Value is left-justified; bits below the selected resolution read zero.
// - Reading temperature never disturbs the background measurement path.
// - New results load only when no read is under way.
// - 16-bit read sends upper byte, master acks, lower byte, master nacks, release.
// - Master ack after the lower byte restarts output with the same held upper byte.
// - Master nack after the upper byte ends the read and releases the data line.
// - Temperature register resets to zero.
// - Write data aimed at the temperature register is dropped and not acknowledged.
// - Configuration works through its upper byte alone; lower byte reads zero.
// - Configuration takes only the first complete data byte after the selector.
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH

`define TSR_PTR_TEMP    2'h0
`define TSR_PTR_CFG     2'h1
`define TSR_PTR_LOW     2'h2
`define TSR_PTR_HIGH    2'h3
`define TSR_PTR_MAX     8'h03
`define TSR_ADDR_FIXED  4'h9
`define TSR_TEMP_RST    16'h0000
`define TSR_CFG_RST     16'h0000
`define TSR_LOW_RST     16'h4B00
`define TSR_HIGH_RST    16'h5000
`define TSR_CFG_OS_BIT  15
`define TSR_CFG_RES_HI  14
`define TSR_CFG_RES_LO  13
`define TSR_MASK_9B     16'hFF80
`define TSR_MASK_10B    16'hFFC0
`define TSR_MASK_11B    16'hFFE0
`define TSR_MASK_12B    16'hFFF0
`define TSR_BITS_BYTE   4'h8

`endif

// [include/tsr_pkg.sv]
package tsr_pkg;

  typedef enum logic [2:0] {
    TSR_IDLE,
    TSR_ADDR,
    TSR_AACK,
    TSR_WDATA,
    TSR_WACK,
    TSR_RDATA,
    TSR_RACK
  } tsr_state_e;

  typedef struct packed {
    logic        scl_m;
    logic        scl_s;
    logic        scl_d;
    logic        sda_m;
    logic        sda_s;
    logic        sda_d;
    logic [2:0]  strap_m;
    logic [2:0]  strap_s;
    logic        req_m;
    logic        req_s;
    tsr_state_e  st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic        rw;
    logic [1:0]  widx;
    logic        rd_hi;
    logic        mack;
    logic        rd_busy;
    logic [1:0]  ptr;
    logic [15:0] temp;
    logic [15:0] cfg;
    logic [15:0] lo;
    logic [15:0] hi;
    logic        ack_t;
    logic        wr_t;
    logic        sda_oe;
    logic        sda_o;
  } tsr_link_s;

  typedef struct packed {
    logic [15:0] word;
    logic        req_t;
    logic        ack_m;
    logic        ack_s;
    logic        wr_m;
    logic        wr_s;
    logic        wr_d;
    logic [15:0] cfg;
    logic [15:0] lo;
    logic [15:0] hi;
  } tsr_main_s;

endpackage

// [src/tsr_regbank.sv]
`timescale 1ns/1ps
`include "tsr_cfg.svh"

module tsr_regbank (
  // System side
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] conv_word_i,
  input  wire logic        conv_valid_i,
  output logic      [15:0] cfg_word_o,
  output logic      [15:0] low_limit_o,
  output logic      [15:0] high_limit_o,
  // Serial link
  input  wire logic        link_clk_i,
  input  wire logic [2:0]  strap_address_bits_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);

  tsr_pkg::tsr_link_s lq;
  tsr_pkg::tsr_link_s ln;
  tsr_pkg::tsr_main_s mq;
  tsr_pkg::tsr_main_s mn;

  logic lrst_m;
  logic lrst_b;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic wr_done;
  logic rd_next;
  logic load_ev;
  logic [15:0] res_mask;

  function automatic logic [15:0] sel_word(input logic [1:0] p,
                                           input tsr_pkg::tsr_link_s s);
    logic [15:0] w;
    w = s.temp;
    case (p)
      `TSR_PTR_CFG:  w = s.cfg & ~(16'h0001 << `TSR_CFG_OS_BIT);
      `TSR_PTR_LOW:  w = s.lo;
      `TSR_PTR_HIGH: w = s.hi;
      default:       w = s.temp;
    endcase
    return w;
  endfunction

  // Link reset follows the system reset through two flops of the link clock
  always_ff @(posedge link_clk_i) begin
    lrst_m <= rst_b_i;
    lrst_b <= lrst_m;
  end

  always_comb begin
    case (lq.cfg[`TSR_CFG_RES_HI:`TSR_CFG_RES_LO])
      2'h0:    res_mask = `TSR_MASK_9B;
      2'h1:    res_mask = `TSR_MASK_10B;
      2'h2:    res_mask = `TSR_MASK_11B;
      default: res_mask = `TSR_MASK_12B;
    endcase
  end

  always_comb begin
    logic [15:0] w;
    logic [7:0]  b;
    logic        ack;
    w = 16'h0000;
    b = 8'h00;
    ack = 1'b0;
    ln = lq;
    ln.scl_m = scl_i;
    ln.scl_s = lq.scl_m;
    ln.scl_d = lq.scl_s;
    ln.sda_m = sda_i;
    ln.sda_s = lq.sda_m;
    ln.sda_d = lq.sda_s;
    ln.strap_m = strap_address_bits_i;
    ln.strap_s = lq.strap_m;
    ln.req_m = mq.req_t;
    ln.req_s = lq.req_m;
    ln.sda_o = 1'b0;
    scl_rise = lq.scl_s & ~lq.scl_d;
    scl_fall = ~lq.scl_s & lq.scl_d;
    start_ev = lq.scl_s & lq.scl_d & lq.sda_d & ~lq.sda_s;
    stop_ev = lq.scl_s & lq.scl_d & ~lq.sda_d & lq.sda_s;
    wr_done = 1'b0;
    rd_next = 1'b0;
    // An unfinished byte is simply dropped when start or stop cuts it
    if (start_ev) begin
      ln.st = tsr_pkg::TSR_ADDR;
      ln.cnt = 4'h0;
      ln.sda_oe = 1'b0;
      ln.rd_busy = 1'b0;
    end else if (stop_ev) begin
      ln.st = tsr_pkg::TSR_IDLE;
      ln.sda_oe = 1'b0;
      ln.rd_busy = 1'b0;
    end else begin
      case (lq.st)
        tsr_pkg::TSR_IDLE: begin
          ln.sda_oe = 1'b0;
        end
        tsr_pkg::TSR_ADDR: begin
          if (scl_rise) begin
            ln.sh = {lq.sh[6:0], lq.sda_s};
            ln.cnt = lq.cnt + 4'h1;
          end else if (scl_fall && lq.cnt == `TSR_BITS_BYTE) begin
            if (lq.sh[7:1] == {`TSR_ADDR_FIXED, lq.strap_s}) begin
              ln.st = tsr_pkg::TSR_AACK;
              ln.sda_oe = 1'b1;
              ln.rw = lq.sh[0];
              ln.rd_busy = lq.sh[0];
              ln.widx = 2'h0;
              ln.rd_hi = 1'b1;
            end else begin
              ln.st = tsr_pkg::TSR_IDLE;
            end
          end
        end
        tsr_pkg::TSR_AACK: begin
          if (scl_fall) begin
            ln.cnt = 4'h0;
            if (lq.rw) begin
              // Reads always use the stored selector
              w = sel_word(lq.ptr, lq);
              ln.tx = w[15:8];
              ln.sda_oe = ~w[15];
              ln.st = tsr_pkg::TSR_RDATA;
            end else begin
              ln.sda_oe = 1'b0;
              ln.st = tsr_pkg::TSR_WDATA;
            end
          end
        end
        tsr_pkg::TSR_WDATA: begin
          if (scl_rise) begin
            ln.sh = {lq.sh[6:0], lq.sda_s};
            ln.cnt = lq.cnt + 4'h1;
          end else if (scl_fall && lq.cnt == `TSR_BITS_BYTE) begin
            wr_done = 1'b1;
            b = lq.sh;
            ack = 1'b1;
            if (lq.widx == 2'h0) begin
              // First byte of every write is the selector
              if (b <= `TSR_PTR_MAX) begin
                ln.ptr = b[1:0];
              end
            end else begin
              case (lq.ptr)
                `TSR_PTR_TEMP: begin
                  ack = 1'b0;
                end
                `TSR_PTR_CFG: begin
                  if (lq.widx == 2'h1) begin
                    ln.cfg = {b, 8'h00};
                    ln.wr_t = ~lq.wr_t;
                  end
                end
                `TSR_PTR_LOW: begin
                  if (lq.widx == 2'h1) begin
                    ln.lo = {b, lq.lo[7:0]};
                    ln.wr_t = ~lq.wr_t;
                  end else if (lq.widx == 2'h2) begin
                    ln.lo = {lq.lo[15:8], b};
                    ln.wr_t = ~lq.wr_t;
                  end
                end
                default: begin
                  if (lq.widx == 2'h1) begin
                    ln.hi = {b, lq.hi[7:0]};
                    ln.wr_t = ~lq.wr_t;
                  end else if (lq.widx == 2'h2) begin
                    ln.hi = {lq.hi[15:8], b};
                    ln.wr_t = ~lq.wr_t;
                  end
                end
              endcase
            end
            ln.sda_oe = ack;
            ln.widx = (lq.widx == 2'h3) ? 2'h3 : lq.widx + 2'h1;
            ln.st = tsr_pkg::TSR_WACK;
          end
        end
        tsr_pkg::TSR_WACK: begin
          if (scl_fall) begin
            ln.sda_oe = 1'b0;
            ln.cnt = 4'h0;
            ln.st = tsr_pkg::TSR_WDATA;
          end
        end
        tsr_pkg::TSR_RDATA: begin
          if (scl_rise) begin
            ln.cnt = lq.cnt + 4'h1;
          end else if (scl_fall) begin
            if (lq.cnt == `TSR_BITS_BYTE) begin
              ln.sda_oe = 1'b0;
              ln.st = tsr_pkg::TSR_RACK;
            end else begin
              ln.tx = {lq.tx[6:0], 1'b0};
              ln.sda_oe = ~lq.tx[6];
            end
          end
        end
        tsr_pkg::TSR_RACK: begin
          if (scl_rise) begin
            ln.mack = ~lq.sda_s;
          end else if (scl_fall) begin
            if (lq.mack) begin
              // Ack after the lower byte starts over at the upper byte
              rd_next = 1'b1;
              w = sel_word(lq.ptr, lq);
              ln.rd_hi = ~lq.rd_hi;
              ln.tx = lq.rd_hi ? w[7:0] : w[15:8];
              ln.sda_oe = lq.rd_hi ? ~w[7] : ~w[15];
              ln.cnt = 4'h0;
              ln.st = tsr_pkg::TSR_RDATA;
            end else begin
              ln.sda_oe = 1'b0;
              ln.rd_busy = 1'b0;
              ln.st = tsr_pkg::TSR_IDLE;
            end
          end
        end
        default: begin
          ln.st = tsr_pkg::TSR_IDLE;
          ln.sda_oe = 1'b0;
        end
      endcase
    end
    // Result waits in the crossing register until the read is over
    load_ev = (lq.req_s != lq.ack_t) && !lq.rd_busy;
    if (load_ev) begin
      ln.temp = mq.word & res_mask;
      ln.ack_t = ~lq.ack_t;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!lrst_b) begin
      lq <= '0;
      lq.scl_m <= 1'b1;
      lq.scl_s <= 1'b1;
      lq.scl_d <= 1'b1;
      lq.sda_m <= 1'b1;
      lq.sda_s <= 1'b1;
      lq.sda_d <= 1'b1;
      lq.st <= tsr_pkg::TSR_IDLE;
      lq.ptr <= `TSR_PTR_TEMP;
      lq.temp <= `TSR_TEMP_RST;
      lq.cfg <= `TSR_CFG_RST;
      lq.lo <= `TSR_LOW_RST;
      lq.hi <= `TSR_HIGH_RST;
    end else begin
      lq <= ln;
    end
  end

  // A result arriving while the previous one is still in flight is dropped
  always_comb begin
    mn = mq;
    mn.ack_m = lq.ack_t;
    mn.ack_s = mq.ack_m;
    mn.wr_m = lq.wr_t;
    mn.wr_s = mq.wr_m;
    mn.wr_d = mq.wr_s;
    if (conv_valid_i && (mq.ack_s == mq.req_t)) begin
      mn.word = conv_word_i;
      mn.req_t = ~mq.req_t;
    end
    if (mq.wr_s != mq.wr_d) begin
      mn.cfg = lq.cfg;
      mn.lo = lq.lo;
      mn.hi = lq.hi;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mq <= '0;
      mq.cfg <= `TSR_CFG_RST;
      mq.lo <= `TSR_LOW_RST;
      mq.hi <= `TSR_HIGH_RST;
    end else begin
      mq <= mn;
    end
  end

  assign cfg_word_o = mq.cfg;
  assign low_limit_o = mq.lo;
  assign high_limit_o = mq.hi;
  assign sda_o = lq.sda_o;
  assign sda_oe_o = lq.sda_oe;

  chk_ptr_bad_hold: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (wr_done && lq.widx == 2'h0 && lq.sh > `TSR_PTR_MAX) |=> $stable(lq.ptr) && lq.sda_oe)
    else $error("invalid selector changed pointer or was not acked");

  chk_ptr_good_load: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (wr_done && lq.widx == 2'h0 && lq.sh <= `TSR_PTR_MAX) |=> lq.ptr == $past(lq.sh[1:0]))
    else $error("selector byte not loaded");

  chk_temp_write_nack: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    // A finished conversion may still land in that same cycle; only the write is dropped
    (wr_done && lq.widx != 2'h0 && lq.ptr == `TSR_PTR_TEMP)
      |=> !lq.sda_oe && ($past(load_ev) || $stable(lq.temp)))
    else $error("temperature write was acknowledged");

  chk_read_hold: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    lq.rd_busy |=> $stable(lq.temp))
    else $error("temperature changed during read");

  chk_res_mask: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    load_ev |=> (lq.temp == ($past(mq.word) & $past(res_mask))) && (lq.temp[3:0] == 4'h0))
    else $error("loaded temperature not masked to resolution");

  chk_cfg_low_zero: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (wr_done && lq.ptr == `TSR_PTR_CFG && lq.widx == 2'h1) |=> lq.cfg == {$past(lq.sh), 8'h00})
    else $error("configuration byte not stored in upper half");

  chk_cfg_once: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (wr_done && lq.ptr == `TSR_PTR_CFG && lq.widx > 2'h1) |=> $stable(lq.cfg))
    else $error("extra configuration byte accepted");

  chk_reset_ptr: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    $rose(lrst_b) |-> lq.ptr == `TSR_PTR_TEMP)
    else $error("selector not at temperature after reset");

  chk_reset_temp: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    $rose(lrst_b) |-> lq.temp == `TSR_TEMP_RST)
    else $error("temperature not cleared by reset");

  chk_nack_release: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (lq.st == tsr_pkg::TSR_RACK && scl_fall && !lq.mack && !start_ev && !stop_ev)
      |=> ((lq.st == tsr_pkg::TSR_IDLE) && !lq.sda_oe) [*2])
    else $error("data line not released after master nack");

  chk_wrap_upper: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (rd_next && !lq.rd_hi && !start_ev && !stop_ev)
      |=> lq.rd_hi && ({8'h00, lq.tx} == (sel_word(lq.ptr, lq) >> 8)))
    else $error("read did not restart at upper byte");

  chk_read_ptr_keep: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (lq.rw && lq.st != tsr_pkg::TSR_IDLE && lq.st != tsr_pkg::TSR_ADDR) |=> $stable(lq.ptr))
    else $error("selector moved during read");

  chk_addr_ack: assert property (
    @(posedge link_clk_i) disable iff (!lrst_b)
    (lq.st == tsr_pkg::TSR_AACK) |-> lq.sda_oe)
    else $error("address byte not acknowledged");

endmodule

// [sim/tsr_i2c_master.sv]
`timescale 1ns/1ps

module tsr_i2c_master (
  // Wire side
  input  wire logic       lclk_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_oe_o,
  // Notes of what came back
  output logic            res_stb_o,
  output logic [7:0]      res_val_o
);
  initial begin
    scl_o     = 1'b1;
    sda_oe_o  = 1'b0;
    res_stb_o = 1'b0;
    res_val_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk_i);
    #1;
  endtask

  task automatic note(input logic [7:0] v);
    res_val_o = v;
    res_stb_o = 1'b1;
    tick(1);
    res_stb_o = 1'b0;
  endtask

  // SDA only moves while SCL is low, so no bit looks like a frame edge
  task automatic put_bit(input logic b, output logic r);
    sda_oe_o = !b;
    tick(8);
    scl_o = 1'b1;
    tick(4);
    r = sda_i;
    tick(4);
    scl_o = 1'b0;
    tick(2);
  endtask

  task automatic start();
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
    tick(4);
  endtask

  task automatic stop();
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b0;
    tick(8);
  endtask

  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    note({7'h00, r});
  endtask

  // Ack asks for another byte, not-ack ends the read
  task automatic rbyte(input logic mack);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      v[i] = r;
    end
    put_bit(!mack, r);
    note(v);
  endtask
endmodule

// [sim/tsr_regbank_test.sv]
`timescale 1ns/1ps

module tsr_regbank_test;
  localparam logic [2:0] STRAP = 3'h5;
  logic        mclk, lclk, rst_b, conv_valid, scl, m_oe, dev_oe, res_stb, dev_do, cut_bit;
  logic [15:0] conv_word, cfg_w, lo_w, hi_w, t;
  logic [7:0]  res_val;
  wire         sda = !(dev_oe | m_oe);
  logic [7:0]  exp_q[$];
  string       nam_q[$];
  int          err_count, check_count;
  logic [31:0] seed = 32'h37;
  logic [15:0] masks[4] = '{16'hFF80, 16'hFFC0, 16'hFFE0, 16'hFFF0};

  tsr_regbank tsr_regbank_i (
    .mclk_i(mclk), .rst_b_i(rst_b), .conv_word_i(conv_word), .conv_valid_i(conv_valid),
    .cfg_word_o(cfg_w), .low_limit_o(lo_w), .high_limit_o(hi_w), .link_clk_i(lclk),
    .strap_address_bits_i(STRAP), .scl_i(scl), .sda_i(sda), .sda_o(dev_do), .sda_oe_o(dev_oe)
  );
  tsr_i2c_master mst_i (
    .lclk_i(lclk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe),
    .res_stb_o(res_stb), .res_val_o(res_val)
  );

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  initial lclk = 1'b0;
  always #6 lclk = ~lclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic expb(input string n, input logic [7:0] v);
    exp_q.push_back(v);
    nam_q.push_back(n);
  endtask

  always @(posedge lclk) begin
    if (res_stb === 1'b1) begin
      chk("sda_o", {15'h0000, dev_do}, 16'h0000);
      if (exp_q.size() == 0) begin
        chk("spare byte", {8'h00, res_val}, 16'hFFFF);
      end else begin
        chk(nam_q.pop_front(), {8'h00, res_val}, {8'h00, exp_q.pop_front()});
      end
    end
  end

  task automatic wr(input logic [7:0] sel, input logic [15:0] d, input int n,
                    input logic [1:0] ae);
    expb("addr ack", 8'h00);
    expb("sel ack", 8'h00);
    mst_i.start();
    mst_i.wbyte({4'h9, STRAP, 1'b0});
    mst_i.wbyte(sel);
    for (int i = 0; i < n; i++) begin
      expb("data ack", {7'h00, ae[1-i]});
      mst_i.wbyte(d[15-8*i -: 8]);
    end
    mst_i.stop();
  endtask

  task automatic rd(input logic [23:0] e, input int n);
    expb("addr ack", 8'h00);
    mst_i.start();
    mst_i.wbyte({4'h9, STRAP, 1'b1});
    for (int i = 0; i < n; i++) begin
      expb("rdata", e[23-8*i -: 8]);
      mst_i.rbyte(i < n - 1);
    end
    mst_i.stop();
  endtask

  // The wait after the pulse stands for the conversion time before trusting data
  task automatic conv(input logic [15:0] w);
    @(posedge mclk);
    #1;
    conv_word = w;
    conv_valid = 1'b1;
    @(posedge mclk);
    #1;
    conv_valid = 1'b0;
    repeat (40) @(posedge mclk);
  endtask

  task automatic stop_test();
    if (exp_q.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    conv_valid = 1'b0;
    conv_word = 16'h0000;
    repeat (10) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    repeat (10) @(posedge lclk);
    chk("cfg_word_o", cfg_w, 16'h0000);
    chk("low_limit_o", lo_w, 16'h4B00);
    chk("high_limit_o", hi_w, 16'h5000);
    rd(24'h000000, 2);
    $display("reset test done");
    expb("foreign addr", 8'h01);
    mst_i.start();
    mst_i.wbyte({4'h9, ~STRAP, 1'b0});
    mst_i.stop();
    wr(8'h01, 16'hE0FF, 2, 2'b00);
    chk("cfg_word_o", cfg_w, 16'hE000);
    rd(24'h600000, 2);
    rd(24'h600000, 2);
    // A byte cut short by stop must leave the configuration alone
    expb("addr ack", 8'h00);
    expb("sel ack", 8'h00);
    mst_i.start();
    mst_i.wbyte({4'h9, STRAP, 1'b0});
    mst_i.wbyte(8'h01);
    for (int i = 0; i < 7; i++) begin
      mst_i.put_bit(1'b0, cut_bit);
    end
    mst_i.stop();
    chk("cfg_word_o", cfg_w, 16'hE000);
    $display("config test done");
    for (int r = 0; r < 4; r++) begin
      void'(xs());
      t = {r[0], seed[14:0]};
      wr(8'h01, {1'b0, r[1:0], 13'h0000}, 1, 2'b00);
      conv(t);
      wr(8'h00, 16'h0000, 0, 2'b00);
      rd({t & masks[r], 8'h00}, 2);
    end
    t = t & 16'hFFF0;
    $display("resolution test done");
    rd({t, t[15:8]}, 3);
    rd({t[15:8], 16'h0000}, 1);
    wr(8'h00, 16'hAB00, 1, 2'b10);
    wr(8'h05, 16'h0000, 0, 2'b00);
    rd({t, 8'h00}, 2);
    $display("refusal test done");
    wr(8'h02, 16'h1234, 2, 2'b00);
    wr(8'h03, 16'hE6C0, 2, 2'b00);
    chk("low_limit_o", lo_w, 16'h1234);
    chk("high_limit_o", hi_w, 16'hE6C0);
    wr(8'h02, 16'h0000, 0, 2'b00);
    rd({16'h1234, 8'h00}, 2);
    wr(8'h03, 16'h0000, 0, 2'b00);
    rd({16'hE6C0, 8'h00}, 2);
    $display("limit test done");
    wr(8'h00, 16'h0000, 0, 2'b00);
    expb("addr ack", 8'h00);
    mst_i.start();
    mst_i.wbyte({4'h9, STRAP, 1'b1});
    conv(16'h3280);
    expb("held upper", t[15:8]);
    mst_i.rbyte(1'b1);
    expb("held lower", t[7:0]);
    mst_i.rbyte(1'b0);
    mst_i.stop();
    rd(24'h328000, 2);
    $display("hold-off test done");
    stop_test();
  end
endmodule
